// file: araw_top.sv
// Result accumulate, format and window block of a successive-approximation converter.
// Assumes a core that takes a start pulse and returns a 10-bit code with a done pulse.
//
// Notes on behaviour
// - Publish result high and low bytes
// - Code 000 right, 100 left justified
// - Repeat one gives plain 10-bit code
// - Unused result bits read zero
// - Series sum published after last sample
// - Accumulate 4, 8, 16, 32, 64 samples
// - 16-bit sum, optional right shift 1-3
// - One trigger runs whole burst
// - Power-up wait once per burst, none when held on
// - Always-on and burst may coexist
// - Every new result checked against limits
// - Two 16-bit limits in byte registers
// - Lower above upper: inside window detection
// - Limit contents select inside or outside
// - Window flag readable by software
// - Done flag per conversion or burst
// - Triggers during a burst are ignored
`timescale 1ns/1ns
`default_nettype none
module araw_top
  import araw_pkg::*;
#(
  parameter int unsigned POWERUP_TICKS = POWERUP_TICKS_DEF
)(
  input  wire logic              CLK_SYS,
  input  wire logic              RESETN,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic              START_TRIG,
  output logic                   SAR_CLK_EN,
  output logic                   SAR_POWER,
  output logic                   SAR_START,
  input  wire logic              SAR_DONE,
  input  wire logic [9:0]        SAR_CODE,
  output logic                   TWELVE_BIT_MODE,
  output logic                   BUSY,
  output logic                   CONV_DONE,
  output logic                   WINDOW_MATCH
);
  generate
    if (POWERUP_TICKS < 1 || POWERUP_TICKS > 255) begin : g_chk
      $error("araw_top: POWERUP_TICKS out of range");
    end
  endgenerate

  localparam logic [7:0] PWRUP_LAST = 8'(POWERUP_TICKS - 1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic        power_enable_reg;
  logic        burst_enable_reg;
  logic        done_flag_reg;
  logic        done_flag_next;
  logic        win_flag_reg;
  logic        win_flag_next;
  logic [7:0]  acc_cfg_reg;
  logic [15:0] upper_reg;
  logic [15:0] lower_reg;
  logic [4:0]  div_reg;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic [15:0] acc_reg;
  logic [15:0] acc_next;
  logic [6:0]  cnt_reg;
  logic [6:0]  cnt_next;
  logic [7:0]  pwr_cnt_reg;
  logic [7:0]  pwr_cnt_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  araw_state_t state_reg;
  araw_state_t state_next;
  araw_win_if  win_if ();

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire         wr_ctrl    = WR && (ADDR == OFF_CTRL);
  wire         wr_cfg     = WR && (ADDR == OFF_ACC_CFG);
  wire         wr_up_hi   = WR && (ADDR == OFF_UPPER_HI);
  wire         wr_up_lo   = WR && (ADDR == OFF_UPPER_LO);
  wire         wr_lo_hi   = WR && (ADDR == OFF_LOWER_HI);
  wire         wr_lo_lo   = WR && (ADDR == OFF_LOWER_LO);
  wire         wr_div     = WR && (ADDR == OFF_CLK_DIV);
  wire [2:0]   just_sel   = acc_cfg_reg[CFG_JUST_LSB +: 3];
  wire [2:0]   rpt_sel    = acc_cfg_reg[CFG_RPT_LSB +: 3];
  wire [6:0]   rpt_target = araw_rpt_count(rpt_sel);
  wire         tick;
  wire         idle       = (state_reg == ST_IDLE);
  wire [7:0]   ctrl_rd    = {power_enable_reg, burst_enable_reg, done_flag_reg, !idle, win_flag_reg, 3'h0};

  // Software start rides on the busy bit; anything outside idle is dropped
  wire         trigger    = START_TRIG || (wr_ctrl && WDATA[CTRL_BUSY_BIT]);
  wire         accept     = idle && trigger;
  wire         sample_in  = (state_reg == ST_WAIT) && SAR_DONE;
  wire [15:0]  sum_total  = acc_reg + {6'h00, SAR_CODE};
  wire         last       = (cnt_reg == rpt_target - 7'h01);
  wire         publish    = sample_in && last;
  wire         burst_more = sample_in && burst_enable_reg && !last;

  // Formatting; left justify keeps only a single 10-bit code sensible
  wire [15:0]  fmt_val    = (just_sel == JUST_SHR1) ? {1'b0, sum_total[15:1]} :
                            (just_sel == JUST_SHR2) ? {2'h0, sum_total[15:2]} :
                            (just_sel == JUST_SHR3) ? {3'h0, sum_total[15:3]} :
                            (just_sel == JUST_LEFT) ? {sum_total[9:0], 6'h00} :
                            sum_total;

  assign result_next = publish ? fmt_val : result_reg;
  assign acc_next    = publish ? 16'h0000 : (sample_in ? sum_total : acc_reg);
  assign cnt_next    = publish ? 7'h00 : (sample_in ? cnt_reg + 7'h01 : cnt_reg);

  // Flags: hardware set beats a software clear in the same cycle
  wire         done_set   = publish && burst_enable_reg
                            || sample_in && !burst_enable_reg;
  assign done_flag_next = done_set || (wr_ctrl ? WDATA[CTRL_DONE_BIT] : done_flag_reg);
  assign win_flag_next  = win_if.match || (wr_ctrl ? WDATA[CTRL_WIN_BIT] : win_flag_reg);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Power-up wait only from idle with the converter not held on
  always_comb
  begin
    state_next   = state_reg;
    pwr_cnt_next = pwr_cnt_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        pwr_cnt_next = 8'h00;
        if (accept) state_next = power_enable_reg ? ST_START : ST_PWRUP;
      end
      ST_PWRUP:
      begin
        if (tick)
        begin
          pwr_cnt_next = pwr_cnt_reg + 8'h01;
          if (pwr_cnt_reg == PWRUP_LAST) state_next = ST_START;
        end
      end
      ST_START:
      begin
        if (tick) state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (burst_more)     state_next = ST_START;
        else if (sample_in) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  assign SAR_START       = (state_reg == ST_START) && tick;
  assign SAR_CLK_EN      = tick;
  assign SAR_POWER       = power_enable_reg || !idle;
  assign TWELVE_BIT_MODE = acc_cfg_reg[CFG_12B_BIT];
  assign BUSY            = !idle;
  assign CONV_DONE       = done_flag_reg;
  assign WINDOW_MATCH    = win_flag_reg;
  assign RDATA           = rdata_reg;

  // ----------------------------------------------------------------
  // Read mux, answered one cycle after the strobe
  // ----------------------------------------------------------------
  assign rdata_next = !RD ? 8'h00 :
                      (ADDR == OFF_CTRL)     ? ctrl_rd :
                      (ADDR == OFF_ACC_CFG)  ? acc_cfg_reg :
                      (ADDR == OFF_RES_HI)   ? result_reg[15:8] :
                      (ADDR == OFF_RES_LO)   ? result_reg[7:0] :
                      (ADDR == OFF_UPPER_HI) ? upper_reg[15:8] :
                      (ADDR == OFF_UPPER_LO) ? upper_reg[7:0] :
                      (ADDR == OFF_LOWER_HI) ? lower_reg[15:8] :
                      (ADDR == OFF_LOWER_LO) ? lower_reg[7:0] :
                      (ADDR == OFF_CLK_DIV)  ? {3'h0, div_reg} : 8'h00;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      power_enable_reg <= CTRL_RST[CTRL_PWR_BIT];
      burst_enable_reg <= CTRL_RST[CTRL_BURST_BIT];
      acc_cfg_reg      <= CFG_RST;
      div_reg          <= CLK_DIV_RST;
    end
    else
    begin
      if (wr_ctrl) power_enable_reg <= WDATA[CTRL_PWR_BIT];
      if (wr_ctrl) burst_enable_reg <= WDATA[CTRL_BURST_BIT];
      if (wr_cfg)  acc_cfg_reg      <= {1'b0, WDATA[6:0]};
      if (wr_div)  div_reg          <= WDATA[4:0];
    end
  end

  // Limit bytes, each written on its own
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      upper_reg <= LIMIT_RST;
      lower_reg <= LIMIT_RST;
    end
    else
    begin
      if (wr_up_hi) upper_reg[15:8] <= WDATA;
      if (wr_up_lo) upper_reg[7:0]  <= WDATA;
      if (wr_lo_hi) lower_reg[15:8] <= WDATA;
      if (wr_lo_lo) lower_reg[7:0]  <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Datapath and state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      state_reg     <= ST_IDLE;
      pwr_cnt_reg   <= 8'h00;
      acc_reg       <= 16'h0000;
      cnt_reg       <= 7'h00;
      result_reg    <= 16'h0000;
      done_flag_reg <= 1'b0;
      win_flag_reg  <= 1'b0;
      rdata_reg     <= 8'h00;
    end
    else
    begin
      state_reg     <= state_next;
      pwr_cnt_reg   <= pwr_cnt_next;
      acc_reg       <= acc_next;
      cnt_reg       <= cnt_next;
      result_reg    <= result_next;
      done_flag_reg <= done_flag_next;
      win_flag_reg  <= win_flag_next;
      rdata_reg     <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  logic       upd_reg;

  // Window check sees the result the cycle after it is stored
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN) upd_reg <= 1'b0;
    else         upd_reg <= publish;
  end

  assign win_if.result      = result_reg;
  assign win_if.update      = upd_reg;
  assign win_if.upper_limit = upper_reg;
  assign win_if.lower_limit = lower_reg;

  araw_clkdiv #(.DIV_W(5)) u_div (
    .clk    (CLK_SYS),
    .rst_n  (RESETN),
    .divide (div_reg),
    .tick   (tick)
  );

  araw_window u_win (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .w     (win_if)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_no_retrigger : assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!idle && state_reg != ST_PWRUP) |=> state_reg != ST_PWRUP)
    else $error("power-up re-entered during a burst");
  chk_left_low_zero : assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (publish && just_sel == JUST_LEFT) |=> result_reg[5:0] == 6'h00)
    else $error("left justified result has low bits set");
  chk_single_upper_zero : assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (publish && rpt_sel == 3'h0 && just_sel == JUST_RIGHT) |=> result_reg[15:10] == 6'h00)
    else $error("single right justified result exceeds 10 bits");
  chk_result_on_last : assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !$stable(result_reg) |-> $past(publish))
    else $error("result changed before the series ended");
  chk_series_count : assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    cnt_reg < rpt_target || $changed(rpt_sel))
    else $error("sample count beyond repeat setting");
  chk_burst_done : assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    ($rose(done_flag_reg) && burst_enable_reg && !$past(wr_ctrl)) |-> $past(publish))
    else $error("done flag set mid burst");
  chk_win_flag_read : assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (RD && ADDR == OFF_CTRL) |=> RDATA[CTRL_WIN_BIT] == $past(win_flag_reg))
    else $error("window flag read back wrong");
  chk_win_flag_set : assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    win_if.match |=> win_flag_reg)
    else $error("window match did not set the flag");
  cov_burst_four : cover property (@(posedge CLK_SYS) disable iff (!RESETN)
    publish && burst_enable_reg && rpt_sel == 3'h1);
  cov_always_on_burst : cover property (@(posedge CLK_SYS) disable iff (!RESETN)
    accept && power_enable_reg && burst_enable_reg);
  cov_trigger_dropped : cover property (@(posedge CLK_SYS) disable iff (!RESETN)
    trigger && !idle);

endmodule
`default_nettype wire

// file: araw_pkg.sv
// Constants, register map and types for the result accumulate and window block.
// Assumes an 8-bit register port with a 4-bit address.
package araw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 8;
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_ACC_CFG   = 4'h1;
  localparam logic [3:0]  OFF_RES_HI    = 4'h2;
  localparam logic [3:0]  OFF_RES_LO    = 4'h3;
  localparam logic [3:0]  OFF_UPPER_HI  = 4'h4;
  localparam logic [3:0]  OFF_UPPER_LO  = 4'h5;
  localparam logic [3:0]  OFF_LOWER_HI  = 4'h6;
  localparam logic [3:0]  OFF_LOWER_LO  = 4'h7;
  localparam logic [3:0]  OFF_CLK_DIV   = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_PWR_BIT  = 7;
  localparam int unsigned CTRL_BURST_BIT = 6;
  localparam int unsigned CTRL_DONE_BIT = 5;
  localparam int unsigned CTRL_BUSY_BIT = 4;
  localparam int unsigned CTRL_WIN_BIT  = 3;
  localparam int unsigned CFG_12B_BIT   = 6;
  localparam int unsigned CFG_JUST_LSB  = 3;
  localparam int unsigned CFG_RPT_LSB   = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [15:0] LIMIT_RST     = 16'h0000;
  localparam logic [4:0]  CLK_DIV_RST   = 5'h1F;
  localparam logic [2:0]  JUST_RIGHT    = 3'h0;
  localparam logic [2:0]  JUST_SHR1     = 3'h1;
  localparam logic [2:0]  JUST_SHR2     = 3'h2;
  localparam logic [2:0]  JUST_SHR3     = 3'h3;
  localparam logic [2:0]  JUST_LEFT     = 3'h4;
  localparam int unsigned POWERUP_TICKS_DEF = 4;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_PWRUP = 4'b0010,
    ST_START = 4'b0100,
    ST_WAIT  = 4'b1000
  } araw_state_t;

  // Samples per series for each repeat code; codes above 5 act as 64
  function automatic logic [6:0] araw_rpt_count(input logic [2:0] sel);
    logic [6:0] n;
    n = 7'h40;
    if (sel == 3'h0) n = 7'h01;
    else if (sel <= 3'h5) n = 7'(4 << (sel - 3'h1));
    return n;
  endfunction

endpackage

// file: araw_win_if.sv
// Link between the result path and the window detector.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface araw_win_if;
  logic [15:0] result;
  logic        update;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic        match;

  modport core (output result, output update, output upper_limit, output lower_limit, input match);
  modport det  (input result, input update, input upper_limit, input lower_limit, output match);
endinterface
`default_nettype wire

// file: araw_clkdiv.sv
// Conversion clock enable: one tick every divide+1 system clocks.
// Assumes a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module araw_clkdiv
  import araw_pkg::*;
#(
  parameter int unsigned DIV_W = 5
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] divide,
  output logic                  tick
);
  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_chk
      $error("araw_clkdiv: DIV_W out of range");
    end
  endgenerate

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;

  // A counter above a freshly lowered divide ticks at once and restarts from zero
  assign tick     = (cnt_reg >= divide);
  assign cnt_next = tick ? '0 : cnt_reg + 1'b1;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n) cnt_reg <= '0;
    else        cnt_reg <= cnt_next;
  end

  // Only a divide of zero in the following cycle may tick twice in a row
  chk_tick_spacing : assert property (@(posedge clk) disable iff (!rst_n)
    (tick ##1 divide != '0) |-> !tick)
    else $error("conversion tick repeated too soon");

endmodule
`default_nettype wire

// file: araw_window.sv
// Window detector: compares each new result with the two limits.
// Assumes update is a one-cycle pulse beside a stable result.
`timescale 1ns/1ns
`default_nettype none
module araw_window
  import araw_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  araw_win_if.det   w
);
  logic inside_mode;
  logic inside_hit;
  logic outside_hit;
  logic match_reg;

  // Limit order alone picks inside or outside detection
  assign inside_mode = (w.lower_limit > w.upper_limit);
  assign inside_hit  = (w.result > w.upper_limit) && (w.result < w.lower_limit);
  assign outside_hit = (w.result > w.upper_limit) || (w.result < w.lower_limit);
  assign w.match     = match_reg;

  // ----------------------------------------------------------------
  // Match pulse, one cycle after each result update that hits the window
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n) match_reg <= 1'b0;
    else        match_reg <= w.update && (inside_mode ? inside_hit : outside_hit);
  end

  chk_inside_window : assert property (@(posedge clk) disable iff (!rst_n)
    (w.update && inside_mode && !inside_hit) |=> !w.match)
    else $error("inside window flagged out of range result");
  chk_outside_window : assert property (@(posedge clk) disable iff (!rst_n)
    (w.update && !inside_mode && outside_hit) |=> w.match)
    else $error("outside window missed a result");
  cov_inside_hit : cover property (@(posedge clk) disable iff (!rst_n)
    w.update && inside_mode && inside_hit);

endmodule
`default_nettype wire

// file: araw_sar_model.sv
// Behavioural model of the converter core that faces the result block.
// Assumes one start pulse per conversion and a single shared system clock.
`timescale 1ns/1ns
`default_nettype none
module araw_sar_model
  import araw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [9:0] code_in,
  output logic            done,
  output logic      [9:0] code
);
  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  logic [2:0] cnt_reg;
  logic       slow_reg;
  logic [9:0] last_reg;

  // Latency alternates between prompt and slow so the sequencer never sees a fixed gap
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= 3'h0;
      done     <= 1'b0;
      slow_reg <= 1'b0;
      last_reg <= 10'h000;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_reg  <= slow_reg ? 3'h4 : 3'h1;
        slow_reg <= ~slow_reg;
      end
      else if (cnt_reg == 3'h1)
      begin
        done     <= 1'b1;
        last_reg <= code_in;
        cnt_reg  <= 3'h0;
      end
      else if (cnt_reg != 3'h0)
        cnt_reg <= cnt_reg - 3'h1;
    end
  end

  // Code is only valid beside done; otherwise show the inverse so stale values cannot pass
  assign code = done ? last_reg : ~last_reg;
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the result accumulate and window block.
// Assumes the converter core model beside it and a 20 MHz system clock.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb
  import araw_pkg::*;
;
  logic       CLK_SYS = 1'b0, RESETN = 1'b0, WR = 1'b0, RD = 1'b0, START_TRIG = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, RDATA, d;
  logic       SAR_CLK_EN, SAR_POWER, SAR_START, SAR_DONE, TWELVE_BIT_MODE, BUSY, CONV_DONE, WINDOW_MATCH;
  logic [9:0] SAR_CODE, code_in = 10'h000;
  int         mismatches = 0, checks = 0, starts = 0;

  // ----------------------------------------------------------------
  // Clock, design and core model
  // ----------------------------------------------------------------
  always #25 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) if (SAR_START === 1'b1) starts++;

  araw_top #(.POWERUP_TICKS(2)) i_araw_top (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .START_TRIG(START_TRIG), .SAR_CLK_EN(SAR_CLK_EN), .SAR_POWER(SAR_POWER),
    .SAR_START(SAR_START), .SAR_DONE(SAR_DONE), .SAR_CODE(SAR_CODE), .TWELVE_BIT_MODE(TWELVE_BIT_MODE),
    .BUSY(BUSY), .CONV_DONE(CONV_DONE), .WINDOW_MATCH(WINDOW_MATCH));
  araw_sar_model i_araw_sar_model (.clk(CLK_SYS), .rst_n(RESETN), .start(SAR_START), .code_in(code_in),
    .done(SAR_DONE), .code(SAR_CODE));

  // ----------------------------------------------------------------
  // Bus and sequencing tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    WR <= 1'b1; ADDR <= a; WDATA <= v;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample at the edge closing it
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge CLK_SYS);
    RD <= 1'b1; ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    @(posedge CLK_SYS);
    v = RDATA;
  endtask

  // One trigger, optionally a second one while busy that must be dropped
  task automatic run(input bit extra);
    int i;
    starts = 0;
    @(posedge CLK_SYS); START_TRIG <= 1'b1;
    @(posedge CLK_SYS); START_TRIG <= 1'b0;
    if (extra)
    begin
      repeat (3) @(posedge CLK_SYS);
      START_TRIG <= 1'b1;
      @(posedge CLK_SYS); START_TRIG <= 1'b0;
    end
    // Busy is read one edge late, once the accepting edge has settled it
    for (i = 0; i < 4000; i++)
    begin
      @(posedge CLK_SYS);
      if (BUSY === 1'b0) break;
    end
    if (i == 4000)
    begin
      mismatches++;
      report_and_stop();
    end
    repeat (4) @(posedge CLK_SYS);
  endtask

  task automatic chk_result(input logic [15:0] exp);
    logic [7:0] h, l;
    rd(OFF_RES_HI, h);
    rd(OFF_RES_LO, l);
    `CHK("result", exp, {h, l})
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_CTRL, d);    `CHK("ctrl rst", CTRL_RST, d)
    rd(OFF_ACC_CFG, d); `CHK("cfg rst", CFG_RST, d)
    rd(OFF_CLK_DIV, d); `CHK("div rst", {3'h0, CLK_DIV_RST}, d)
    rd(4'hF, d);        `CHK("unmapped", 8'h00, d)
    `CHK("busy rst", 1'b0, BUSY)
    $display("test reset done");
  endtask

  task automatic t_clkdiv();
    int i;
    wr(OFF_CLK_DIV, 8'h03);
    for (i = 0; i < 40 && SAR_CLK_EN !== 1'b1; i++) @(posedge CLK_SYS);
    @(posedge CLK_SYS);
    for (i = 1; i < 40 && SAR_CLK_EN !== 1'b1; i++) @(posedge CLK_SYS);
    `CHK("tick gap", 4, i)
    wr(OFF_CLK_DIV, 8'h00);
    $display("test clock divide done");
  endtask

  task automatic t_format();
    wr(OFF_CTRL, 8'h80);
    wr(OFF_ACC_CFG, {2'b00, JUST_RIGHT, 3'h0});
    code_in = 10'h3FF;
    run(0);
    `CHK("starts single", 1, starts)
    `CHK("done flag", 1'b1, CONV_DONE)
    chk_result(16'h03FF);
    wr(OFF_CTRL, 8'h80);
    @(posedge CLK_SYS);
    `CHK("done cleared", 1'b0, CONV_DONE)
    wr(OFF_ACC_CFG, {2'b00, JUST_LEFT, 3'h0});
    run(0);
    chk_result(16'hFFC0);
    code_in = 10'h200;
    run(0);
    chk_result(16'h8000);
    $display("test format done");
  endtask

  // Burst with repeat codes 1 to 5 and every right shift; software keeps right justify
  task automatic t_accum();
    int         n;
    logic [2:0] j;
    code_in = 10'h3FF;
    for (int s = 1; s <= 5; s++)
    begin
      n = 4 << (s - 1);
      j = 3'((s - 1) & 3);
      wr(OFF_CTRL, (s == 5) ? 8'hC0 : 8'h40);
      wr(OFF_ACC_CFG, {2'b00, j, 3'(s)});
      run(1);
      `CHK("burst starts", n, starts)
      `CHK("burst done", 1'b1, CONV_DONE)
      `CHK("power idle", (s == 5), SAR_POWER)
      chk_result(16'((32'h3FF * n) >> j));
    end
    wr(OFF_ACC_CFG, 8'h41);
    @(posedge CLK_SYS);
    `CHK("twelve bit", 1'b1, TWELVE_BIT_MODE)
    $display("test accumulate done");
  endtask

  task automatic t_window();
    logic [15:0] up [5] = '{16'h0040, 16'h0040, 16'h0080, 16'h0080, 16'h0080};
    logic [15:0] lo [5] = '{16'h0080, 16'h0080, 16'h0040, 16'h0040, 16'h0040};
    logic [9:0]  cd [5] = '{10'h060, 10'h040, 10'h030, 10'h080, 10'h081};
    logic        ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    wr(OFF_ACC_CFG, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      wr(OFF_CTRL, 8'h80);
      wr(OFF_UPPER_HI, up[k][15:8]); wr(OFF_UPPER_LO, up[k][7:0]);
      wr(OFF_LOWER_HI, lo[k][15:8]); wr(OFF_LOWER_LO, lo[k][7:0]);
      code_in = cd[k];
      run(0);
      `CHK("window pin", ex[k], WINDOW_MATCH)
      rd(OFF_CTRL, d);
      `CHK("window bit", ex[k], d[CTRL_WIN_BIT])
    end
    $display("test window done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    t_reset();
    t_clkdiv();
    t_format();
    t_accum();
    t_window();
    report_and_stop();
  end
endmodule
`default_nettype wire
